// File: gdiag_checker.sv
module gdiag_checker (
    input wire i_clock,
    input wire i_rst_b,
    input wire i_sample_tick,
    input wire i_reg_wr,
    input wire i_reg_rd,
    input wire [5:0] i_reg_addr,
    input wire [15:0] i_reg_wdata,
    input wire i_alarm2,
    input wire i_comm_fail,
    input wire i_flash_fail,
    input wire i_supply_high,
    input wire i_supply_low,
    input wire [15:0] o_reg_rdata,
    input wire o_stim_pos,
    input wire o_stim_neg,
    input wire [7:0] o_mem_addr
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_b);
    wire rdf = i_reg_rd && (i_reg_addr == 6'h3c);
    wire wrm = i_reg_wr && (i_reg_addr == 6'h34);
    // Comm and flash events land on any cycle, alarm and overrange only on a tick
    wire quiet = !i_sample_tick && !i_comm_fail && !i_flash_fail;
    a_unused_zero: assert property (rdf |=>
        o_reg_rdata[15:10] == 6'h00 && !o_reg_rdata[7])
        else $error("unused flag bit set");
    a_read_clears: assert property (rdf && quiet ##1 rdf && quiet |=>
        o_reg_rdata[9:8] == 2'h0 && o_reg_rdata[4:2] == 3'h0)
        else $error("flag survived a read");
    a_event_kept: assert property (i_comm_fail && rdf ##1 rdf |=>
        o_reg_rdata[3]) else $error("event lost during read");
    a_alarm_seen: assert property (i_alarm2 && i_sample_tick ##1
        !i_reg_rd ##1 rdf |=> o_reg_rdata[9]) else $error("alarm missing");
    a_supply_high: assert property (i_supply_high[*6] ##0 rdf |=>
        o_reg_rdata[1]) else $error("supply high flag missing");
    a_supply_clear: assert property ((!i_supply_low)[*6] ##0 rdf |=>
        !o_reg_rdata[0]) else $error("supply low flag stuck");
    a_stim_excl: assert property (!(o_stim_pos && o_stim_neg))
        else $error("both stimuli on");
    a_pos_stim: assert property (wrm && i_reg_wdata[10:8] == 3'h1 |->
        ##[1:2] o_stim_pos && !o_stim_neg) else $error("no positive stim");
    a_neg_stim: assert property (wrm && i_reg_wdata[10:8] == 3'h2 |->
        ##[1:2] o_stim_neg && !o_stim_pos) else $error("no negative stim");
    a_stim_off: assert property (wrm && i_reg_wdata[10:8] == 3'h0 |->
        ##2 !o_stim_pos && !o_stim_neg) else $error("stim not removed");
    // The checksum walk must never leave the sixteen compared words
    a_mem_addr_range: assert property (o_mem_addr < 8'h10)
        else $error("memory address out of range");
    c_st_fail: cover property (rdf ##1 o_reg_rdata[5]);
    c_mem_fail: cover property (rdf ##1 o_reg_rdata[6]);
    c_neg: cover property (o_stim_neg);
endmodule
bind gdiag_status gdiag_checker i_chk (.i_clock, .i_rst_b, .i_sample_tick,
    .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .i_alarm2, .i_comm_fail,
    .i_flash_fail, .i_supply_high, .i_supply_low, .o_reg_rdata, .o_stim_pos,
    .o_stim_neg, .o_mem_addr);

// File: gdiag_consts.vh
`ifndef GDIAG_CONSTS_VH
`define GDIAG_CONSTS_VH
// ----------------------------------------
// Register map
// ----------------------------------------
`define GDIAG_ADDR_FLAGS 6'h3c
`define GDIAG_ADDR_MISC 6'h34
`define GDIAG_MISC_RESET 16'h0006
`define GDIAG_FLAGS_RESET 16'h0000
// ----------------------------------------
// Field positions
// ----------------------------------------
`define GDIAG_MISC_MEMTEST 11
`define GDIAG_MISC_AUTOST 10
`define GDIAG_MISC_NEG 9
`define GDIAG_MISC_POS 8
`define GDIAG_FLAG_ALM2 9
`define GDIAG_FLAG_ALM1 8
`define GDIAG_FLAG_MEM 6
`define GDIAG_FLAG_ST 5
`define GDIAG_FLAG_OVR 4
`define GDIAG_FLAG_COMM 3
`define GDIAG_FLAG_FLASH 2
`define GDIAG_FLAG_HIGH 1
`define GDIAG_FLAG_LOW 0
`define GDIAG_FLAG_USED 16'h037f
`define GDIAG_FLAG_COR 16'h037c
// ----------------------------------------
// Timing
// ----------------------------------------
`define GDIAG_SETTLE_SAMPLES 8'h08
`define GDIAG_MEM_WORDS 8'h10
`endif

// File: gdiag_memcheck.v
`include "gdiag_consts.vh"
module gdiag_memcheck (
    input wire i_clock,
    input wire i_rst_b,
    input wire i_start,
    input wire [15:0] i_flash_word,
    input wire [15:0] i_sram_word,
    output reg [7:0] o_addr,
    output wire o_busy,
    output reg o_done,
    output reg o_fail
);
    reg busy_reg;
    reg [15:0] flash_sum_reg;
    reg [15:0] sram_sum_reg;
    assign o_busy = busy_reg;
    // ----------------------------------------
    // Walk both memories, accumulate sums
    // ----------------------------------------
    always @(posedge i_clock) begin
        if (!i_rst_b) begin
            busy_reg <= 1'b0;
            o_addr <= 8'h00;
            o_done <= 1'b0;
            o_fail <= 1'b0;
            flash_sum_reg <= 16'h0000;
            sram_sum_reg <= 16'h0000;
        end else begin
            o_done <= 1'b0;
            if (!busy_reg) begin
                if (i_start) begin
                    busy_reg <= 1'b1;
                    o_addr <= 8'h00;
                    flash_sum_reg <= 16'h0000;
                    sram_sum_reg <= 16'h0000;
                end
            end else begin
                flash_sum_reg <= flash_sum_reg + i_flash_word;
                sram_sum_reg <= sram_sum_reg + i_sram_word;
                if (o_addr == `GDIAG_MEM_WORDS - 8'h01) begin
                    busy_reg <= 1'b0;
                    o_done <= 1'b1;
                    o_fail <= ((flash_sum_reg + i_flash_word) !=
                               (sram_sum_reg + i_sram_word));
                end else begin
                    o_addr <= o_addr + 8'h01;
                end
            end
        end
    end
endmodule

// File: gdiag_sensor_model.sv
module gdiag_sensor_model (
    input wire i_stim_pos,
    input wire i_stim_neg,
    input wire i_bad,
    input wire [7:0] i_mem_addr,
    output logic [15:0] o_rate,
    output logic [15:0] o_flash,
    output logic [15:0] o_sram
);
    timeunit 1ns;
    timeprecision 100ps;
    // A weak element moves far less than the pass window asks
    wire [15:0] shift = i_bad ? 16'h0004 : 16'h0100;
    wire [15:0] pos = i_stim_pos ? shift : 16'h0000;
    // Held at rest, so only the stimulus moves the output
    assign o_rate = 16'h0020 + pos - (i_stim_neg ? shift : 16'h0000);
    assign o_flash = {i_mem_addr, ~i_mem_addr};
    // One flipped bit in word 5 stands for a corrupted copy
    assign o_sram = o_flash ^ {15'h0000, i_bad && i_mem_addr == 8'h05};
endmodule

// File: gdiag_status.v
`include "gdiag_consts.vh"
module gdiag_status (
    input wire i_clock,
    input wire i_rst_b,
    input wire i_sample_tick,
    input wire i_reg_wr,
    input wire i_reg_rd,
    input wire [5:0] i_reg_addr,
    input wire [15:0] i_reg_wdata,
    input wire [15:0] i_rate_sample,
    input wire [15:0] i_st_limit_lo,
    input wire [15:0] i_st_limit_hi,
    input wire i_alarm1,
    input wire i_alarm2,
    input wire i_overrange,
    input wire i_comm_fail,
    input wire i_flash_fail,
    input wire i_supply_high,
    input wire i_supply_low,
    input wire [15:0] i_flash_word,
    input wire [15:0] i_sram_word,
    output reg [15:0] o_reg_rdata,
    output wire [7:0] o_mem_addr,
    output reg o_stim_pos,
    output reg o_stim_neg
);
    // ----------------------------------------
    // State and storage
    // ----------------------------------------
    localparam ST_IDLE = 2'b00;
    localparam ST_BASE = 2'b01;
    localparam ST_POS = 2'b10;
    localparam ST_JUDGE = 2'b11;
    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [15:0] misc_reg;
    reg [15:0] flags_reg;
    reg [15:0] flags_next;
    reg [7:0] wait_reg;
    reg [7:0] wait_next;
    reg [15:0] base_reg;
    reg [15:0] base_next;
    reg st_fail_reg;
    reg st_fail_next;
    reg st_done;
    reg [15:0] delta;
    reg [2:0] sup_sync_reg [0:1];
    wire mem_busy;
    wire mem_done;
    wire mem_fail;
    wire sup_high;
    wire sup_low;
    wire [15:0] flag_events;
    wire rd_flags;
    // ----------------------------------------
    // Supply comparators sit off-clock
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_sync
            wire raw_in;
            assign raw_in = (g == 0) ? i_supply_low : i_supply_high;
            always @(posedge i_clock) begin
                if (!i_rst_b) begin
                    sup_sync_reg[g] <= 3'b000;
                end else begin
                    sup_sync_reg[g] <= {sup_sync_reg[g][1:0], raw_in};
                end
            end
        end
    endgenerate
    // Level counts only when the two later stages agree
    reg [1:0] sup_level_reg;
    always @(posedge i_clock) begin
        if (!i_rst_b) begin
            sup_level_reg <= 2'b00;
        end else begin
            if (sup_sync_reg[0][2] == sup_sync_reg[0][1]) begin
                sup_level_reg[0] <= sup_sync_reg[0][2];
            end
            if (sup_sync_reg[1][2] == sup_sync_reg[1][1]) begin
                sup_level_reg[1] <= sup_sync_reg[1][2];
            end
        end
    end
    assign sup_low = sup_level_reg[0];
    assign sup_high = sup_level_reg[1];
    // ----------------------------------------
    // Memory checksum engine
    // ----------------------------------------
    gdiag_memcheck u_memcheck (
        .i_clock(i_clock),
        .i_rst_b(i_rst_b),
        .i_start(misc_reg[`GDIAG_MISC_MEMTEST] & ~mem_busy & ~mem_done),
        .i_flash_word(i_flash_word),
        .i_sram_word(i_sram_word),
        .o_addr(o_mem_addr),
        .o_busy(mem_busy),
        .o_done(mem_done),
        .o_fail(mem_fail)
    );
    // ----------------------------------------
    // Automatic self-test sequencer
    // ----------------------------------------
    always @* begin
        state_next = state_reg;
        wait_next = wait_reg;
        base_next = base_reg;
        st_fail_next = st_fail_reg;
        st_done = 1'b0;
        delta = i_rate_sample - base_reg;
        case (state_reg)
            ST_IDLE: begin
                if (misc_reg[`GDIAG_MISC_AUTOST]) begin
                    state_next = ST_BASE;
                    wait_next = `GDIAG_SETTLE_SAMPLES;
                end
            end
            ST_BASE: begin
                // Unstimulated reading taken after the filter settles
                if (i_sample_tick) begin
                    if (wait_reg == 8'h00) begin
                        base_next = i_rate_sample;
                        state_next = ST_POS;
                        wait_next = `GDIAG_SETTLE_SAMPLES;
                    end else begin
                        wait_next = wait_reg - 8'h01;
                    end
                end
            end
            ST_POS: begin
                if (i_sample_tick) begin
                    if (wait_reg == 8'h00) begin
                        state_next = ST_JUDGE;
                    end else begin
                        wait_next = wait_reg - 8'h01;
                    end
                end
            end
            ST_JUDGE: begin
                // Signed limits: response shift must land inside window
                st_fail_next = ($signed(delta) < $signed(i_st_limit_lo)) ||
                               ($signed(delta) > $signed(i_st_limit_hi));
                st_done = 1'b1;
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end
    always @(posedge i_clock) begin
        if (!i_rst_b) begin
            state_reg <= ST_IDLE;
            wait_reg <= 8'h00;
            base_reg <= 16'h0000;
            st_fail_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            wait_reg <= wait_next;
            base_reg <= base_next;
            st_fail_reg <= st_fail_next;
        end
    end
    // ----------------------------------------
    // Control register
    // ----------------------------------------
    always @(posedge i_clock) begin
        if (!i_rst_b) begin
            misc_reg <= `GDIAG_MISC_RESET;
        end else begin
            if (i_reg_wr && i_reg_addr == `GDIAG_ADDR_MISC) begin
                misc_reg <= {4'h0, i_reg_wdata[11:0]};
            end
            // Completion wins over a write landing the same cycle
            if (st_done) begin
                misc_reg[`GDIAG_MISC_AUTOST] <= 1'b0;
            end
            if (mem_done) begin
                misc_reg[`GDIAG_MISC_MEMTEST] <= 1'b0;
            end
        end
    end
    // ----------------------------------------
    // Stimulus drive
    // ----------------------------------------
    always @(posedge i_clock) begin
        if (!i_rst_b) begin
            o_stim_pos <= 1'b0;
            o_stim_neg <= 1'b0;
        end else begin
            // Auto routine overrides manual field while running
            o_stim_pos <= (state_reg == ST_POS) ||
                          (state_reg == ST_IDLE &&
                           misc_reg[9:8] == 2'b01);
            o_stim_neg <= (state_reg == ST_IDLE &&
                           misc_reg[9:8] == 2'b10);
        end
    end
    // ----------------------------------------
    // Diagnostic flags
    // ----------------------------------------
    assign rd_flags = i_reg_rd && (i_reg_addr == `GDIAG_ADDR_FLAGS);
    assign flag_events = {6'h00,
        i_alarm2 & i_sample_tick,
        i_alarm1 & i_sample_tick,
        1'b0,
        mem_done & mem_fail,
        st_done & st_fail_next,
        i_overrange & i_sample_tick,
        i_comm_fail,
        i_flash_fail,
        2'b00};
    always @* begin
        flags_next = flags_reg;
        if (rd_flags) begin
            flags_next = flags_reg & ~`GDIAG_FLAG_COR;
        end
        // Set after clear so a same-cycle event is kept
        flags_next = flags_next | flag_events;
        flags_next[`GDIAG_FLAG_HIGH] = sup_high;
        flags_next[`GDIAG_FLAG_LOW] = sup_low;
        flags_next = flags_next & `GDIAG_FLAG_USED;
    end
    always @(posedge i_clock) begin
        if (!i_rst_b) begin
            flags_reg <= `GDIAG_FLAGS_RESET;
        end else begin
            flags_reg <= flags_next;
        end
    end
    // ----------------------------------------
    // Read data
    // ----------------------------------------
    always @(posedge i_clock) begin
        if (!i_rst_b) begin
            o_reg_rdata <= 16'h0000;
        end else if (i_reg_rd) begin
            case (i_reg_addr)
                `GDIAG_ADDR_FLAGS: o_reg_rdata <= flags_reg;
                `GDIAG_ADDR_MISC: o_reg_rdata <= misc_reg;
                default: o_reg_rdata <= 16'h0000;
            endcase
        end
    end
endmodule

// File: gyro_diagnostics_status_tb_top.sv
module gyro_diagnostics_status_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_clock = 0, i_rst_b = 0, i_sample_tick = 0, i_reg_wr = 0;
    logic i_reg_rd = 0, i_alarm1 = 0, i_alarm2 = 0, i_overrange = 0;
    logic i_comm_fail = 0, i_flash_fail = 0, i_supply_high = 0;
    logic i_supply_low = 0, bad = 0, o_stim_pos, o_stim_neg;
    logic [5:0] i_reg_addr = 6'h00;
    logic [15:0] i_reg_wdata = 16'h0000, i_rate_sample, i_flash_word;
    logic [15:0] i_sram_word, o_reg_rdata;
    logic [15:0] i_st_limit_lo = 16'h0080, i_st_limit_hi = 16'h0200;
    logic [7:0] o_mem_addr;
    logic [2:0] tcnt = 3'h0;
    logic [31:0] lfsr = 32'h0f73e1c7;
    logic [31:0] exp_q[$];
    int error_cnt = 0, cmp_count = 0, cyc = 0;
    gdiag_status i_dut (.i_clock, .i_rst_b, .i_sample_tick, .i_reg_wr,
        .i_reg_rd, .i_reg_addr, .i_reg_wdata, .i_rate_sample, .i_st_limit_lo,
        .i_st_limit_hi, .i_alarm1, .i_alarm2, .i_overrange, .i_comm_fail,
        .i_flash_fail, .i_supply_high, .i_supply_low, .i_flash_word,
        .i_sram_word, .o_reg_rdata, .o_mem_addr, .o_stim_pos, .o_stim_neg);
    gdiag_sensor_model i_far (.i_stim_pos(o_stim_pos), .i_stim_neg(o_stim_neg),
        .i_bad(bad), .i_mem_addr(o_mem_addr), .o_rate(i_rate_sample),
        .o_flash(i_flash_word), .o_sram(i_sram_word));
    always #12.5 i_clock = ~i_clock;
    always @(posedge i_clock) begin
        tcnt <= tcnt + 3'h1;
        i_sample_tick <= (tcnt == 3'h7);
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            print_verdict();
        end
    end
    // ----------------------------------------
    // Bus tasks and result checking
    // ----------------------------------------
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge i_clock);
        i_reg_wr <= 1'b1;
        i_reg_addr <= a;
        i_reg_wdata <= d;
        @(posedge i_clock);
        i_reg_wr <= 1'b0;
    endtask
    // Mask of zero marks a poll whose data is only looked at by the caller
    task automatic rd(input logic [5:0] a, input logic [15:0] e, m);
        @(posedge i_clock);
        i_reg_rd <= 1'b1;
        i_reg_addr <= a;
        exp_q.push_back({m, e});
        @(posedge i_clock);
        i_reg_rd <= 1'b0;
    endtask
    task automatic check_word(input logic [31:0] n);
        if (n[31:16] != 16'h0000) begin
            cmp_count++;
            if ((o_reg_rdata & n[31:16]) !== n[15:0]) begin
                error_cnt++;
                $display("[FAIL] o_reg_rdata expected %h seen %h", n[15:0],
                    o_reg_rdata & n[31:16]);
            end
        end
    endtask
    always @(posedge i_clock) begin
        if (i_reg_rd) begin
            #1;
            check_word(exp_q.pop_front());
        end
    end
    task automatic run_test(input logic [15:0] c, input int b, fb,
        input logic f);
        int k = 0;
        wr(6'h34, c);
        do begin
            rd(6'h34, 16'h0000, 16'h0000);
            #2;
            k++;
        end while (o_reg_rdata[b] !== 1'b0 && k < 200);
        if (k == 200)
            error_cnt++;
        rd(6'h3c, 16'(f) << fb, 16'h0001 << fb);
        rd(6'h34, 16'h0000, 16'h0c00);
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        logic [5:0] a;
        repeat (4) @(posedge i_clock);
        i_rst_b <= 1'b1;
        rd(6'h34, 16'h0006, 16'hffff);
        rd(6'h3c, 16'h0000, 16'hffff);
        repeat (4) begin
            lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
            a = lfsr[5:0];
            if (a == 6'h34 || a == 6'h3c)
                a = a ^ 6'h01;
            wr(a, lfsr[31:16]);
            rd(a, 16'h0000, 16'hffff);
        end
        wr(6'h34, lfsr[15:0] & 16'hf0ff);
        rd(6'h34, {13'h0000, lfsr[2:0]}, 16'hf007);
        wr(6'h34, 16'h0200);
        repeat (8) @(posedge i_clock);
        wr(6'h34, 16'h0100);
        repeat (8) @(posedge i_clock);
        wr(6'h34, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            bad <= i[0];
            run_test(i[1] ? 16'h0800 : 16'h0400, i[1] ? 11 : 10,
                i[1] ? 6 : 5, i[0]);
        end
        bad <= 1'b0;
        {i_alarm1, i_alarm2, i_overrange, i_comm_fail} <= 4'hf;
        {i_flash_fail, i_supply_high} <= 2'h3;
        @(posedge i_clock);
        {i_comm_fail, i_flash_fail} <= 2'h0;
        repeat (20) @(posedge i_clock);
        @(posedge i_clock iff i_sample_tick);
        rd(6'h3c, 16'h031e, 16'hffff);
        {i_alarm1, i_alarm2, i_overrange} <= 3'h0;
        @(posedge i_clock);
        i_reg_rd <= 1'b1;
        i_reg_addr <= 6'h3c;
        i_comm_fail <= 1'b1;
        exp_q.push_back(32'hffff0002);
        @(posedge i_clock);
        i_comm_fail <= 1'b0;
        exp_q.push_back(32'hffff000a);
        @(posedge i_clock);
        exp_q.push_back(32'hffff0002);
        @(posedge i_clock);
        i_reg_rd <= 1'b0;
        rd(6'h3c, 16'h0002, 16'hffff);
        {i_supply_high, i_supply_low} <= 2'h1;
        repeat (8) @(posedge i_clock);
        rd(6'h3c, 16'h0001, 16'hffff);
        i_supply_low <= 1'b0;
        repeat (8) @(posedge i_clock);
        rd(6'h3c, 16'h0000, 16'hffff);
        i_overrange <= 1'b1;
        repeat (10) @(posedge i_clock);
        rd(6'h3c, 16'h0010, 16'h0010);
        repeat (10) @(posedge i_clock);
        rd(6'h3c, 16'h0010, 16'h0010);
        print_verdict();
    end
endmodule
